// ---- core/rtaf_avg.sv ----
// Running mean of remote results over 1, 4 or 8 samples.
// Assumes one-cycle sample strobes on the block clock.
`timescale 1ns/1ps
`default_nettype none
module rtaf_avg #(
	parameter int W = 12
) (
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic [1:0]   sel,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	output logic [W-1:0]      out_data
);
	logic [W-1:0]   hist_r [8];
	logic [W+2:0]   sum4;
	logic [W+2:0]   sum8;

	// Shift history; only valid samples enter
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < 8; i++)
				hist_r[i] <= '0;
		end
		else if (in_valid)
		begin
			hist_r[0] <= in_data;
			for (int i = 1; i < 8; i++)
				hist_r[i] <= hist_r[i-1];
		end
	end

	always_comb
	begin
		sum4 = {3'h0, in_data} + {3'h0, hist_r[0]} + {3'h0, hist_r[1]} + {3'h0, hist_r[2]};
		sum8 = sum4 + {3'h0, hist_r[3]} + {3'h0, hist_r[4]} + {3'h0, hist_r[5]}
			+ {3'h0, hist_r[6]};
	end

	// Unused codes fall back to no averaging
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end
		else
		begin
			out_valid <= in_valid;
			if (in_valid)
			begin
				case (sel)
					2'h1:    out_data <= sum4[W+1:2];
					2'h2:    out_data <= sum8[W+2:3];
					default: out_data <= in_data;
				endcase
			end
		end
	end
endmodule // rtaf_avg
`default_nettype wire

// ---- core/rtaf_core.sv ----
// Alert qualification, ideality correction, averaging and maker code registers.
// Assumes a bus engine delivering pointer writes and reads as one-cycle strobes.
// All inputs are synchronous to the one block clock; reset is synchronous.
`include "rtaf_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module rtaf_core #(
	parameter logic [7:0] MAKER_CODE = `RTAF_MAKER_CODE_DEFAULT, // Arbitrary value
	parameter int         TEMP_W     = 12
) (
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic [7:0]        ptr,
	input  wire logic              wr_stb,
	input  wire logic [7:0]        wr_data,
	input  wire logic              rd_stb,
	output logic [7:0]             rd_data,
	output logic                   rd_valid,
	output logic                   rd_hit,
	input  wire logic              meas_stb,
	input  wire logic              meas_out_of_limit,
	input  wire logic              remote_stb,
	input  wire logic [TEMP_W-1:0] remote_temp,
	input  wire logic              local_stb,
	input  wire logic [TEMP_W-1:0] local_temp,
	output logic                   alarm_flag,
	output logic                   alarm_pin_n_oe,
	output logic                   bus_timeout_enable,
	output logic [7:0]             ideality_adjust_value,
	output logic [11:0]            ideality_divisor,
	output logic                   result_valid,
	output logic                   result_is_remote,
	output logic [TEMP_W-1:0]      result_temp
);
	// Timing at a glance, in rising edges of clock:
	//  - a register write lands on the edge that takes wr_stb, and the
	//    configuration outputs follow one edge later
	//  - a read answer stands one edge after rd_stb and holds until the next read
	//  - the alarm moves only on an edge that takes meas_stb
	//  - a remote result leaves two edges after remote_stb, a local one after one
	// The extra configuration stage keeps the conversion path clear of the bus decode,
	// at the price of one edge of lag that the host never sees.

	// Register images as the host reads them back
	logic [7:0]        alert_qualify_config_r;
	logic [7:0]        ideality_correction_r;
	logic [7:0]        remote_filter_control_r;

	// Alarm run tracking
	logic [2:0]        run_cnt_r;
	logic [2:0]        run_need;
	logic              run_done;

	// Averaging path
	logic              avg_valid;
	logic [TEMP_W-1:0] avg_data;
	rtaf_pkg::rtaf_avg_mode_t avg_mode;
	logic [1:0]        avg_sel;

	// Ideality path
	logic [11:0]       divisor_nxt;

	wire logic [2:0] alarm_run_length_sel =
		alert_qualify_config_r[`RTAF_RUN_SEL_MSB:`RTAF_RUN_SEL_LSB];
	wire logic [1:0] averaging_select =
		remote_filter_control_r[`RTAF_AVG_SEL_MSB:`RTAF_AVG_SEL_LSB];

	// Alert qualification image; reserved bits are stored as written
	// Bit 0 is reserved and resets to one; it reads back whatever was last written
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			alert_qualify_config_r <= `RTAF_ALERT_QUAL_RST;
		else if (wr_stb && (ptr == `RTAF_PTR_ALERT_QUAL))
			alert_qualify_config_r <= wr_data;
	end

	// Ideality adjustment image, kept as the raw signed byte
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			ideality_correction_r <= `RTAF_IDEALITY_RST;
		else if (wr_stb && (ptr == `RTAF_PTR_IDEALITY))
			ideality_correction_r <= wr_data;
	end

	// Filter control image; codes the filter does not use still read back as written
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			remote_filter_control_r <= `RTAF_FILTER_RST;
		else if (wr_stb && (ptr == `RTAF_PTR_FILTER))
			remote_filter_control_r <= wr_data;
	end

	// The maker code pointer matches none of the images, so a write there is dropped
	// and the code stays fixed whatever the host sends

	// Read strobe echo: one pulse per read, one edge late
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			rd_valid <= 1'b0;
		else
			rd_valid <= rd_stb;
	end

	// Hit flag tells the bus engine whether this block owns the pointer just read
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			rd_hit <= 1'b0;
		else if (rd_stb)
		begin
			case (ptr)
				`RTAF_PTR_ALERT_QUAL, `RTAF_PTR_IDEALITY,
				`RTAF_PTR_FILTER, `RTAF_PTR_MAKER:
					rd_hit <= 1'b1;
				default:
					rd_hit <= 1'b0; // Other pointers belong elsewhere
			endcase
		end
	end

	// Read data, held until the next read so a slow bus engine can shift it out
	// Unmapped pointers answer 00h so a shared bus always sees a defined value
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			rd_data <= 8'h00;
		else if (rd_stb)
		begin
			case (ptr)
				`RTAF_PTR_ALERT_QUAL: rd_data <= alert_qualify_config_r;
				`RTAF_PTR_IDEALITY:   rd_data <= ideality_correction_r;
				`RTAF_PTR_FILTER:     rd_data <= remote_filter_control_r;
				`RTAF_PTR_MAKER:      rd_data <= MAKER_CODE;
				default:              rd_data <= 8'h00;
			endcase
		end
	end

	// Thermometer-coded run length; other codes take the highest set bit
	// The host is not expected to write those codes; the highest-bit rule keeps
	// the needed count rising with the code, so nothing odd happens if it does
	always_comb
	begin
		if (alarm_run_length_sel[2])
			run_need = 3'h4;
		else if (alarm_run_length_sel[1])
			run_need = 3'h3;
		else if (alarm_run_length_sel[0])
			run_need = 3'h2;
		else
			run_need = 3'h1;
	end

	// Count an unbroken run of violations, saturating at four
	// Saturation keeps a long violation run from wrapping and dropping the alarm
	// A measurement inside the limits starts the run over
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			run_cnt_r <= 3'h0;
		else if (meas_stb)
		begin
			if (!meas_out_of_limit)
				run_cnt_r <= 3'h0;
			else if (run_cnt_r != 3'h4)
				run_cnt_r <= run_cnt_r + 3'h1;
		end
	end

	// The run is complete when this violation brings the count up to the need
	always_comb
	begin
		run_done = meas_out_of_limit && ((run_cnt_r + 3'h1) >= run_need);
	end

	// Alarm follows the qualified run; pin is open drain, enable low while pulled
	// Flag and pin share one term, so they can never disagree for a cycle
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			alarm_flag     <= 1'b0;
			alarm_pin_n_oe <= 1'b1;
		end
		else if (meas_stb)
		begin
			alarm_flag     <= run_done;
			alarm_pin_n_oe <= !run_done;
		end
	end

	// Signed adjustment extended before adding to the base divisor
	// A zero fill would turn every negative adjustment into a large positive one
	// The sum spans 1960 to 2215, so twelve bits never overflow
	always_comb
	begin
		divisor_nxt = `RTAF_IDEAL_BASE + {{4{ideality_correction_r[7]}}, ideality_correction_r};
	end

	// Time-out enable to the bus engine, one edge behind the register image
	// The bus engine applies the time-out; this block only holds the switch
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			bus_timeout_enable <= 1'b0;
		else
			bus_timeout_enable <= alert_qualify_config_r[`RTAF_BIT_BUS_TIMEOUT];
	end

	// Adjustment and divisor to the conversion path; both move on the same edge
	// so the conversion engine never sees a divisor from a different adjustment
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			ideality_adjust_value <= `RTAF_IDEALITY_RST;
			ideality_divisor      <= `RTAF_IDEAL_BASE;
		end
		else
		begin
			ideality_adjust_value <= ideality_correction_r;
			ideality_divisor      <= divisor_nxt;
		end
	end

	// Decode averaging mode; unused codes act as off
	// The one-hot mode is the single place that decides which codes are live
	always_comb
	begin
		case (averaging_select)
			2'h1:    avg_mode = rtaf_pkg::RTAF_AVG_4;
			2'h2:    avg_mode = rtaf_pkg::RTAF_AVG_8;
			default: avg_mode = rtaf_pkg::RTAF_AVG_OFF;
		endcase
		case (avg_mode)
			rtaf_pkg::RTAF_AVG_4: avg_sel = 2'h1;
			rtaf_pkg::RTAF_AVG_8: avg_sel = 2'h2;
			default:              avg_sel = 2'h0;
		endcase
	end

	// The filter sits on the remote path only; local results never enter it
	rtaf_avg #(
		.W (TEMP_W)
	) u_avg (
		.clock     (clock),
		.rst_n     (rst_n),
		.sel       (avg_sel),
		.in_valid  (remote_stb),
		.in_data   (remote_temp),
		.out_valid (avg_valid),
		.out_data  (avg_data)
	);

	// Remote results pass through the filter, local ones bypass it
	// A local result that collides with a remote one is dropped; the next local
	// conversion replaces it, while a lost remote sample would skew the average
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			result_valid <= 1'b0;
		else
			result_valid <= avg_valid || (local_stb && !remote_stb);
	end

	// Result data and source, held between pulses
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			result_is_remote <= 1'b0;
			result_temp      <= '0;
		end
		else if (avg_valid)
		begin
			result_is_remote <= 1'b1;
			result_temp      <= avg_data;
		end
		else if (local_stb && !remote_stb)
		begin
			result_is_remote <= 1'b0;
			result_temp      <= local_temp;
		end
	end
endmodule // rtaf_core
`default_nettype wire

// ---- shared/rtaf_pkg.sv ----
// Types shared by the alert filter and ideality configuration block.
// Assumes no surroundings; types only.
package rtaf_pkg;
	typedef enum logic [2:0] {
		RTAF_AVG_OFF = 3'h1,
		RTAF_AVG_4   = 3'h2,
		RTAF_AVG_8   = 3'h4
	} rtaf_avg_mode_t;
endpackage

// ---- shared/rtaf_regs.svh ----
// Register map constants for the alert filter and ideality configuration block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef RTAF_REGS_SVH
`define RTAF_REGS_SVH

`define RTAF_PTR_ALERT_QUAL      8'h22
`define RTAF_PTR_IDEALITY        8'h23
`define RTAF_PTR_FILTER          8'h24
`define RTAF_PTR_MAKER           8'hFE

`define RTAF_ALERT_QUAL_RST      8'h01
`define RTAF_IDEALITY_RST        8'h00
`define RTAF_FILTER_RST          8'h00

`define RTAF_BIT_BUS_TIMEOUT     7
`define RTAF_RUN_SEL_MSB         3
`define RTAF_RUN_SEL_LSB         1
`define RTAF_BIT_QUAL_RSVD       0
`define RTAF_AVG_SEL_MSB         1
`define RTAF_AVG_SEL_LSB         0

// Ideality: eff = 1.008 * 2088 / (2088 + adj)
`define RTAF_IDEAL_BASE          12'h828
`define RTAF_MAKER_CODE_DEFAULT  8'hA7

`endif

// ---- verification/remote_temp_alert_filter_config_tb_top.sv ----
// Bench for the alert filter configuration block.
// Assumes rtaf_core with its bound checker and the host bus model.
`timescale 1ns/1ps
`default_nettype none
module remote_temp_alert_filter_config_tb_top;
	logic        clock, rst_n, rd_valid, rd_hit, ms, oor, rs, ls, flag, pin, bto, rv, rr, ws, rds;
	logic [7:0]  ptr, wd, rdd, adj, d;
	logic [11:0] rt, lt, div, res;
	int          n_mismatch = 0, checks_done = 0;
	rtaf_host_model host (.clock(clock), .ptr(ptr), .wr_stb(ws), .wr_data(wd), .rd_stb(rds),
		.rd_data(rdd));
	// Maker code 3Ch is arbitrary
	rtaf_core #(.MAKER_CODE(8'h3C)) dut (.clock(clock), .rst_n(rst_n), .ptr(ptr), .wr_stb(ws),
		.wr_data(wd), .rd_stb(rds), .rd_data(rdd), .rd_valid(rd_valid), .rd_hit(rd_hit),
		.meas_stb(ms), .meas_out_of_limit(oor), .remote_stb(rs), .remote_temp(rt),
		.local_stb(ls), .local_temp(lt), .alarm_flag(flag), .alarm_pin_n_oe(pin),
		.bus_timeout_enable(bto), .ideality_adjust_value(adj), .ideality_divisor(div),
		.result_valid(rv), .result_is_remote(rr), .result_temp(res));
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		$display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Defaults, an unmapped pointer, and a write to the read-only code
	task automatic t_regs;
		host.rd(8'h22, d);
		chk(d, 8'h01);
		host.rd(8'h23, d);
		chk(d, 8'h00);
		host.rd(8'h24, d);
		chk(d, 8'h00);
		host.rd(8'h30, d);
		chk({rd_hit, d}, 9'h000);
		host.wr(8'h22, 8'h8E);
		host.wr(8'hFE, 8'h00);
		host.rd(8'h22, d);
		chk({bto, d}, 9'h18E);
		host.wr(8'h23, 8'h80);
		host.rd(8'h23, d);
		chk({div, d}, 20'h7A880);
		host.rd(8'hFE, d);
		chk({rd_hit, d}, 9'h13C);
		$display("register test done");
	endtask
	task automatic meas(input logic v);
		@(negedge clock);
		ms = 1'b1;
		oor = v;
		@(negedge clock);
		ms = 1'b0;
		oor = ~v;
	endtask
	// Per run code: a broken run and a short run stay quiet, a full run raises
	task automatic t_alarm;
		logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
		for (int i = 0; i < 4; i++)
		begin
			host.wr(8'h22, {4'h0, codes[i], 1'b1});
			repeat (i) meas(1'b1);
			meas(1'b0);
			repeat (i) meas(1'b1);
			chk({flag, pin}, 2'b01);
			meas(1'b1);
			chk({flag, pin}, 2'b10);
		end
		$display("alarm test done");
	endtask
	// Remote answers two cycles on, local one; history starts at zero
	task automatic res_chk(input logic rem, input logic [11:0] v, input logic [11:0] e);
		@(negedge clock);
		rs = rem;
		ls = !rem;
		rt = v;
		lt = v;
		@(negedge clock);
		rs = 1'b0;
		ls = 1'b0;
		if (rem)
			@(negedge clock);
		chk({rv, rr, res}, {1'b1, rem, e});
	endtask
	task automatic t_avg;
		host.wr(8'h24, 8'h02);
		res_chk(1'b1, 12'h050, 12'h00A);
		host.wr(8'h24, 8'h01);
		res_chk(1'b1, 12'h028, 12'h01E);
		res_chk(1'b0, 12'h123, 12'h123);
		host.wr(8'h24, 8'h03);
		res_chk(1'b1, 12'h044, 12'h044);
		host.wr(8'h24, 8'h00);
		res_chk(1'b1, 12'h028, 12'h028);
		$display("averaging test done");
	endtask
	// Mid-run reset returns images and outputs to their reset values
	task automatic t_reset;
		host.wr(8'h22, 8'h81);
		host.wr(8'h23, 8'h7F);
		host.wr(8'h24, 8'h02);
		meas(1'b1);
		chk({bto, flag, pin}, 3'b110);
		@(negedge clock);
		rst_n = 1'b0;
		repeat (2) @(negedge clock);
		rst_n = 1'b1;
		chk({bto, flag, pin}, 3'b001);
		host.rd(8'h22, d);
		chk(d, 8'h01);
		host.rd(8'h23, d);
		chk({div, d}, 20'h82800);
		host.rd(8'h24, d);
		chk(d, 8'h00);
		res_chk(1'b1, 12'h040, 12'h040);
		$display("reset test done");
	endtask
	initial
	begin
		rst_n = 1'b0;
		{ms, oor, rs, ls} = 4'h0;
		rt = 12'h000;
		lt = 12'h000;
		repeat (5) @(negedge clock);
		rst_n = 1'b1;
		t_regs;
		t_alarm;
		t_avg;
		t_reset;
		conclude;
	end
	// A hang ends the run through the same verdict
	initial
	begin
		#20000;
		n_mismatch++;
		conclude;
	end
endmodule // remote_temp_alert_filter_config_tb_top
`default_nettype wire

// ---- verification/rtaf_core_props.sv ----
// Checker for the alert filter configuration block.
// Assumes it is bound to rtaf_core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module rtaf_core_props (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic [7:0]  ptr,
	input wire logic        wr_stb,
	input wire logic [7:0]  wr_data,
	input wire logic        rd_stb,
	input wire logic        rd_valid,
	input wire logic        meas_stb,
	input wire logic        meas_out_of_limit,
	input wire logic        alarm_flag,
	input wire logic        alarm_pin_n_oe,
	input wire logic        bus_timeout_enable,
	input wire logic [7:0]  ideality_adjust_value,
	input wire logic [11:0] ideality_divisor
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Read handshake: one answer per strobe, none without
	rd_answer_a: assert property (rd_stb |=> rd_valid) else $error("read unanswered");
	rd_quiet_a: assert property (!rd_stb |=> !rd_valid) else $error("stray read valid");
	// Register writes reach the outputs one edge after the edge that takes the write
	timeout_write_a: assert property (wr_stb && ptr == 8'h22 |-> ##2
		bus_timeout_enable == $past(wr_data[7], 2)) else $error("timeout bit wrong");
	adjust_write_a: assert property (wr_stb && ptr == 8'h23 |-> ##2
		ideality_adjust_value == $past(wr_data, 2)) else $error("adjust wrong");
	// Signed extension matters: a zero fill would break negative values
	divisor_sum_a: assert property (ideality_divisor ==
		12'h828 + {{4{ideality_adjust_value[7]}}, ideality_adjust_value})
		else $error("divisor wrong");
	maker_ro_a: assert property (wr_stb && ptr == 8'hFE |-> ##2 $stable(bus_timeout_enable) &&
		$stable(ideality_adjust_value)) else $error("write to code pointer took effect");
	// An in-limit measurement ends any run, so no alarm can follow it
	run_break_a: assert property (meas_stb && !meas_out_of_limit |=> !alarm_flag)
		else $error("alarm after in-limit result");
	// Alarm pin and flag agree and change only after a measurement
	pin_flag_a: assert property (alarm_pin_n_oe == !alarm_flag) else $error("pin mismatch");
	flag_stands_a: assert property (!meas_stb |=> $stable(alarm_flag)) else $error("flag moved");
endmodule // rtaf_core_props
bind rtaf_core rtaf_core_props u_props (.clock(clock), .rst_n(rst_n), .ptr(ptr),
	.wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb), .rd_valid(rd_valid),
	.meas_stb(meas_stb), .meas_out_of_limit(meas_out_of_limit),
	.alarm_flag(alarm_flag), .alarm_pin_n_oe(alarm_pin_n_oe),
	.bus_timeout_enable(bus_timeout_enable), .ideality_adjust_value(ideality_adjust_value),
	.ideality_divisor(ideality_divisor));
`default_nettype wire

// ---- verification/rtaf_host_model.sv ----
// Host bus controller model: single-byte pointer writes and reads.
// Assumes the bench calls its tasks; it drives on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module rtaf_host_model (
	input  wire logic       clock,
	output logic [7:0]      ptr,
	output logic            wr_stb,
	output logic [7:0]      wr_data,
	output logic            rd_stb,
	input  wire logic [7:0] rd_data
);
	initial
	begin
		ptr = 8'h00;
		wr_stb = 1'b0;
		wr_data = 8'h00;
		rd_stb = 1'b0;
	end
	// Pointer and data are inverted once released so nothing can lean on a stale value
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		ptr = a;
		wr_data = d;
		wr_stb = 1'b1;
		@(negedge clock);
		wr_stb = 1'b0;
		wr_data = ~d;
		ptr = ~a;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		ptr = a;
		rd_stb = 1'b1;
		@(negedge clock);
		rd_stb = 1'b0;
		ptr = ~a;
		d = rd_data;
	endtask
endmodule // rtaf_host_model
`default_nettype wire
